// ==== hdl/rpm_power_ctrl.sv ====
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Power-mode controller: standby/sleep cycle, radio switch, power-down
// Behaviour
// R01: Cycle runs when config enable bit is set or low-power-on was issued.
// R02: Command-enabled cycle is cancelled by power loss or power-down.
// R03: Active cycle alternates standby with radio on and sleep with it off.
// R04: Standby from standby time; sleep from sleep time scaled by unit bit 1.
// R05: Matching unicast packet with checking on lengthens the standby phase.
// R06: Extension comes from config bits 7:4 or the latest extension command.
// R07: Without further packets the extended standby ends in sleep.
// R08: No extension for broadcast packets or with address checking off.
// R09: Low-power-on and low-power-off commands enable and disable the cycle.
// R10: Commands set extension, standby and sleep lengths; registers report them.
// R11: Radio-off command turns the radio off, radio-on turns it back on.
// R12: Radio off means no wireless traffic until radio-on is given.
// R13: Reset or return from power-down turns the radio on.
// R14: Shutdown pin low removes internal power and stops all functions; register reads are still answered here during power-down.
// R15: Shutdown pin high again resumes normal operation.
// R16: Host must not assert shutdown during a register access.
// R17: Leaving power-down discards all parameters set over the registers.
// R18: Host must not drive serial data during power-down.
// R19: Cycle starts in standby, and each sleep returns to fresh standby.
module rpm_power_ctrl #(
	parameter int TICK_CYCLES = rpm_pkg::TICK_CYCLES
) (
	input wire logic clock, // 50 MHz system clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic shutdown_n, // Shutdown pin, low powers down
	input wire logic rx_match, // Pulse: packet with matching address
	input wire logic rx_broadcast, // Qualifies rx_match as broadcast
	output logic power_en, // Internal power on
	output logic radio_en, // Radio circuit on
	input wire logic [rpm_pkg::AW-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [rpm_pkg::AW-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready // Read data ready
);
	localparam int TW = rpm_pkg::TW;
	localparam int DW = $clog2(TICK_CYCLES);

	typedef struct packed {
		logic sh1;
		logic sh2;
		logic [DW-1:0] div;
		rpm_pkg::rpm_phase_t phase;
		logic [7:0] cfg;
		logic [7:0] stby;
		logic [7:0] dsu;
		logic [7:0] slp;
		logic [7:0] achk;
		logic cmd_lp;
		logic rf_on;
		logic radio;
		logic aw_ok;
		logic [2:0] aw_idx;
		logic w_ok;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rpm_state_t;
	rpm_state_t s_reg, s_next;

	logic pd;
	logic lp_req;
	logic tick;
	logic ext_fire;
	logic wr_fire;
	logic tm_load;
	logic [TW-1:0] tm_val;
	logic [TW-1:0] tm_left;
	logic tm_done;
	logic [TW-1:0] stby_ticks;
	logic [TW-1:0] slp_ticks;
	logic [TW-1:0] ext_ticks;
	logic [7:0] status;

	if (TICK_CYCLES < 2 || rpm_pkg::SLEEP_LONG_MULT * 255 >= 2 ** TW)
	begin : g_chk
		$error("rpm_power_ctrl: unsupported tick or sleep scaling");
	end

	// Derived phase lengths in ticks; a zero time is taken as one tick, ten for sleep with unit bit 1
	// R04 phase lengths
	always_comb
	begin
		stby_ticks = (s_reg.stby == 8'h00) ? TW'(1) : TW'(s_reg.stby);
		slp_ticks = (s_reg.slp == 8'h00) ? TW'(1) : TW'(s_reg.slp);
		if (s_reg.dsu[rpm_pkg::DSU_UNIT_BIT])
			slp_ticks = TW'(slp_ticks * TW'(rpm_pkg::SLEEP_LONG_MULT));
	end

	// R06 extension source
	assign ext_ticks = TW'(s_reg.cfg[rpm_pkg::CFG_EXT_LSB +: 4]);

	// Power and cycle requests
	// R14 power removed
	assign pd = ~s_reg.sh2;
	// R01 cycle request
	assign lp_req = s_reg.cfg[rpm_pkg::CFG_LP_EN_BIT] | s_reg.cmd_lp;
	assign tick = (s_reg.div == DW'(TICK_CYCLES - 1));
	assign wr_fire = s_reg.aw_ok & s_reg.w_ok & ~s_reg.bvalid;

	// R08 unicast and checking only
	assign ext_fire = (s_reg.phase == rpm_pkg::PH_STBY) & rx_match
		& ~rx_broadcast & s_reg.achk[rpm_pkg::ACHK_EN_BIT]
		& (ext_ticks != '0) & ~pd;

	assign status = {3'h0, s_reg.sh2, s_reg.cmd_lp, s_reg.radio,
		s_reg.phase == rpm_pkg::PH_SLEEP, s_reg.phase != rpm_pkg::PH_OFF};

	// Next state: bus slave, commands, phase sequencer, power-down
	always_comb
	begin
		s_next = s_reg;
		tm_load = 1'b0;
		tm_val = stby_ticks;
		// Pin synchroniser
		s_next.sh1 = shutdown_n;
		s_next.sh2 = s_reg.sh1;
		s_next.div = tick ? '0 : DW'(s_reg.div + 1'b1);

		// Address and data may arrive in either order
		if (s_axi_awvalid && s_axi_awready)
		begin
			s_next.aw_ok = 1'b1;
			s_next.aw_idx = s_axi_awaddr[4:2];
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			s_next.w_ok = 1'b1;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready)
			s_next.bvalid = 1'b0;

		// Register write or command once both halves are in
		if (wr_fire)
		begin
			s_next.aw_ok = 1'b0;
			s_next.w_ok = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = rpm_pkg::RESP_OKAY;
			if (pd)
				s_next.bresp = rpm_pkg::RESP_SLVERR;
			else if (s_reg.wstrb[0])
			begin
				case (s_reg.aw_idx)
					rpm_pkg::IDX_STBY_CFG: s_next.cfg = s_reg.wdata[7:0];
					rpm_pkg::IDX_STBY_TIME: s_next.stby = s_reg.wdata[7:0];
					rpm_pkg::IDX_DELIM_UNIT: s_next.dsu = s_reg.wdata[7:0];
					rpm_pkg::IDX_SLEEP_TIME: s_next.slp = s_reg.wdata[7:0];
					rpm_pkg::IDX_ADDR_CHECK: s_next.achk = s_reg.wdata[7:0];
					rpm_pkg::IDX_COMMAND:
					begin
						case (s_reg.wdata[7:0])
							// R09 low-power commands
							rpm_pkg::CMD_LP_ON: s_next.cmd_lp = 1'b1;
							rpm_pkg::CMD_LP_OFF:
							begin
								// Register enable is cleared too, so off
								// really stops the cycle
								s_next.cmd_lp = 1'b0;
								s_next.cfg[rpm_pkg::CFG_LP_EN_BIT] = 1'b0;
							end
							// R10 duration set commands
							rpm_pkg::CMD_EXT_TIME:
								s_next.cfg[rpm_pkg::CFG_EXT_LSB +: 4] =
									s_reg.wdata[11:8];
							rpm_pkg::CMD_STBY_TIME: s_next.stby = s_reg.wdata[15:8];
							rpm_pkg::CMD_SLEEP_TIME: s_next.slp = s_reg.wdata[15:8];
							// R11 radio switch commands
							rpm_pkg::CMD_RADIO_OFF: s_next.rf_on = 1'b0;
							rpm_pkg::CMD_RADIO_ON: s_next.rf_on = 1'b1;
							default: s_next.bresp = rpm_pkg::RESP_SLVERR;
						endcase
					end
					default: s_next.bresp = rpm_pkg::RESP_SLVERR;
				endcase
			end
		end

		// Read channel: one outstanding read, answered next cycle
		if (s_reg.rvalid && s_axi_rready)
			s_next.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_next.rvalid = 1'b1;
			s_next.rresp = rpm_pkg::RESP_OKAY;
			s_next.rdata = '0;
			case (s_axi_araddr[4:2])
				rpm_pkg::IDX_STBY_CFG: s_next.rdata[7:0] = s_reg.cfg;
				rpm_pkg::IDX_STBY_TIME: s_next.rdata[7:0] = s_reg.stby;
				rpm_pkg::IDX_DELIM_UNIT: s_next.rdata[7:0] = s_reg.dsu;
				rpm_pkg::IDX_SLEEP_TIME: s_next.rdata[7:0] = s_reg.slp;
				rpm_pkg::IDX_ADDR_CHECK: s_next.rdata[7:0] = s_reg.achk;
				rpm_pkg::IDX_COMMAND: s_next.rdata = '0;
				rpm_pkg::IDX_STATUS: s_next.rdata[7:0] = status;
				default: s_next.rresp = rpm_pkg::RESP_SLVERR;
			endcase
		end

		// Phase sequencer
		case (s_reg.phase)
			rpm_pkg::PH_OFF:
			begin
				// R19 start in standby
				if (lp_req && !pd)
				begin
					s_next.phase = rpm_pkg::PH_STBY;
					tm_load = 1'b1;
				end
			end
			rpm_pkg::PH_STBY:
			begin
				if (!lp_req)
					s_next.phase = rpm_pkg::PH_OFF;
				else if (ext_fire)
				begin
					// R05 lengthen standby
					tm_load = 1'b1;
					tm_val = TW'(tm_left + ext_ticks);
				end
				else if (tm_done)
				begin
					// R07 expiry to sleep
					s_next.phase = rpm_pkg::PH_SLEEP;
					tm_load = 1'b1;
					tm_val = slp_ticks;
				end
			end
			rpm_pkg::PH_SLEEP:
			begin
				if (!lp_req)
					s_next.phase = rpm_pkg::PH_OFF;
				else if (tm_done)
				begin
					// R19 fresh standby
					s_next.phase = rpm_pkg::PH_STBY;
					tm_load = 1'b1;
				end
			end
			default: s_next.phase = rpm_pkg::PH_OFF;
		endcase

		// Power-down overrides the parameters, command state and phase, and restores defaults
		if (pd)
		begin
			// R17 discard parameters
			s_next.cfg = rpm_pkg::RST_STBY_CFG;
			s_next.stby = rpm_pkg::RST_STBY_TIME;
			s_next.dsu = rpm_pkg::RST_DELIM_UNIT;
			s_next.slp = rpm_pkg::RST_SLEEP_TIME;
			s_next.achk = rpm_pkg::RST_ADDR_CHECK;
			// R02 command enable dropped
			s_next.cmd_lp = 1'b0;
			// R13 radio on after return
			s_next.rf_on = 1'b1;
			s_next.phase = rpm_pkg::PH_OFF;
		end

		// R03 radio off in sleep
		// R12 radio gated by switch
		// R15 resumes once powered
		s_next.radio = s_next.rf_on & s_reg.sh2
			& (s_next.phase != rpm_pkg::PH_SLEEP);
	end

	// Phase length counter
	rpm_phase_timer #(
		.W(TW)
	) u_timer (
		.clock(clock),
		.rst(rst),
		.tick(tick),
		.load(tm_load),
		.load_val(tm_val),
		.remaining(tm_left),
		.done(tm_done)
	);

	// State register; reset leaves the block powered down until the pin
	// has been seen high through the synchroniser
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			s_reg <= '0;
			s_reg.phase <= rpm_pkg::PH_OFF;
			s_reg.cfg <= rpm_pkg::RST_STBY_CFG;
			s_reg.stby <= rpm_pkg::RST_STBY_TIME;
			s_reg.dsu <= rpm_pkg::RST_DELIM_UNIT;
			s_reg.slp <= rpm_pkg::RST_SLEEP_TIME;
			s_reg.achk <= rpm_pkg::RST_ADDR_CHECK;
			s_reg.rf_on <= 1'b1;
		end
		else
			s_reg <= s_next;
	end

	// Outputs
	assign power_en = s_reg.sh2;
	assign radio_en = s_reg.radio;
	assign s_axi_awready = ~s_reg.aw_ok & ~s_reg.bvalid;
	assign s_axi_wready = ~s_reg.w_ok & ~s_reg.bvalid;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = ~s_reg.rvalid;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;

	// Checks on the sequencer and switches
	sequence seq_sleep_end;
		(s_reg.phase == rpm_pkg::PH_SLEEP) && tm_done && lp_req && !pd;
	endsequence
	sequence seq_pd_exit;
		pd ##1 !pd;
	endsequence

	a_pd_radio_off: assert property (@(posedge clock) disable iff (rst) // R14
		pd |-> !power_en ##1 !radio_en)
		else $error("radio or power on during power-down");
	a_sleep_radio_off: assert property (@(posedge clock) disable iff (rst) // R03
		(s_reg.phase == rpm_pkg::PH_SLEEP) |-> !radio_en)
		else $error("radio on during sleep");
	a_pd_exit_clean: assert property (@(posedge clock) disable iff (rst) // R13
		seq_pd_exit |-> s_reg.rf_on && !s_reg.cmd_lp
			&& s_reg.stby == rpm_pkg::RST_STBY_TIME)
		else $error("state not restored on power-down exit");
	a_lp_start: assert property (@(posedge clock) disable iff (rst) // R19
		(s_reg.phase == rpm_pkg::PH_OFF) && lp_req && !pd
			|=> (s_reg.phase == rpm_pkg::PH_STBY) && tm_left == $past(stby_ticks))
		else $error("cycle did not start in standby");
	a_sleep_return: assert property (@(posedge clock) disable iff (rst) // R19
		seq_sleep_end |=> (s_reg.phase == rpm_pkg::PH_STBY)
			&& tm_left == $past(stby_ticks))
		else $error("sleep did not return to fresh standby");
	a_ext_cause: assert property (@(posedge clock) disable iff (rst) // R08
		(tm_left > $past(tm_left)) && $past(s_reg.phase) == rpm_pkg::PH_STBY
			&& $past(s_reg.phase) == s_reg.phase
			|-> $past(rx_match && !rx_broadcast && s_reg.achk[0]))
		else $error("standby lengthened without a matching packet");
	a_ext_amount: assert property (@(posedge clock) disable iff (rst) // R05
		ext_fire && lp_req |=> tm_left == TW'($past(tm_left) + $past(ext_ticks)))
		else $error("standby extension amount wrong");
	a_radio_cmd_off: assert property (@(posedge clock) disable iff (rst) // R11
		wr_fire && !pd && s_reg.wstrb[0] && s_reg.aw_idx == rpm_pkg::IDX_COMMAND
			&& s_reg.wdata[7:0] == rpm_pkg::CMD_RADIO_OFF
			|=> !s_reg.rf_on && !radio_en)
		else $error("radio-off command not obeyed");
	a_bresp_after: assert property (@(posedge clock) disable iff (rst) // R10
		$rose(s_axi_bvalid) |-> $past(s_reg.aw_ok && s_reg.w_ok))
		else $error("write answered before address and data");
endmodule

// ==== hdl/rpm_pkg.sv ====
// Constants, register map and types of the radio power-mode controller
package rpm_pkg;
	// Clock and phase time base
	localparam int CLK_PERIOD_NS = 20;
	localparam int UNIT_TIME_MS = 10;
	localparam int TICK_CYCLES = UNIT_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int SLEEP_LONG_MULT = 10;
	localparam int TW = 12;
	// Register word indices (address bits 4:2) on the AXI4-Lite bus
	localparam int AW = 5;
	localparam logic [2:0] IDX_STBY_CFG = 3'h0;
	localparam logic [2:0] IDX_STBY_TIME = 3'h1;
	localparam logic [2:0] IDX_DELIM_UNIT = 3'h2;
	localparam logic [2:0] IDX_SLEEP_TIME = 3'h3;
	localparam logic [2:0] IDX_ADDR_CHECK = 3'h4;
	localparam logic [2:0] IDX_COMMAND = 3'h5;
	localparam logic [2:0] IDX_STATUS = 3'h6;
	// Values after reset and after leaving power-down
	localparam logic [7:0] RST_STBY_CFG = 8'h09;
	localparam logic [7:0] RST_STBY_TIME = 8'h04;
	localparam logic [7:0] RST_DELIM_UNIT = 8'hc1;
	localparam logic [7:0] RST_SLEEP_TIME = 8'h04;
	localparam logic [7:0] RST_ADDR_CHECK = 8'h8d;
	// Field positions
	localparam int CFG_LP_EN_BIT = 2;
	localparam int CFG_EXT_LSB = 4;
	localparam int DSU_UNIT_BIT = 1;
	localparam int ACHK_EN_BIT = 0;
	// Command codes in byte 0 of the command register, argument in byte 1
	localparam logic [7:0] CMD_LP_ON = 8'h01;
	localparam logic [7:0] CMD_LP_OFF = 8'h02;
	localparam logic [7:0] CMD_EXT_TIME = 8'h03;
	localparam logic [7:0] CMD_STBY_TIME = 8'h04;
	localparam logic [7:0] CMD_SLEEP_TIME = 8'h05;
	localparam logic [7:0] CMD_RADIO_OFF = 8'h06;
	localparam logic [7:0] CMD_RADIO_ON = 8'h07;
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {PH_OFF, PH_STBY, PH_SLEEP} rpm_phase_t;
endpackage

// ==== hdl/rpm_phase_timer.sv ====
`timescale 1ns/1ps
// Down-counter of time-base ticks for one standby or sleep phase
module rpm_phase_timer #(
	parameter int W = 12
) (
	input wire logic clock, // System clock
	input wire logic rst, // Asynchronous reset, active high
	input wire logic tick, // One-cycle time-base enable
	input wire logic load, // Load a new remaining count
	input wire logic [W-1:0] load_val, // Ticks to run, zero means idle
	output logic [W-1:0] remaining, // Ticks still to run
	output logic done // One-cycle pulse when count runs out
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic done;
	} rpm_tmr_t;
	rpm_tmr_t s_reg, s_next;

	if (W < 4)
	begin : g_chk
		$error("rpm_phase_timer: W too small");
	end

	// Load wins over a tick so a reload never loses a count
	always_comb
	begin
		s_next = s_reg;
		s_next.done = 1'b0;
		if (load)
			s_next.cnt = load_val;
		else if (tick && s_reg.cnt != '0)
		begin
			s_next.cnt = s_reg.cnt - 1'b1;
			s_next.done = (s_reg.cnt == W'(1));
		end
	end

	// State register
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign remaining = s_reg.cnt;
	assign done = s_reg.done;
endmodule

// ==== bench/rpm_host_model.sv ====
// Host-side model driving the shutdown pin and received-packet flags
`timescale 1ns/1ps
module rpm_host_model (
	input wire logic clock, // System clock
	input wire logic pd_req, // Ask for power-down
	input wire logic bus_busy, // Register access in progress
	input wire logic pkt_req, // Deliver one matching packet
	input wire logic pkt_bcast, // Packet is broadcast
	output logic shutdown_n, // Shutdown pin, low powers down
	output logic rx_match, // One-cycle packet pulse
	output logic rx_broadcast // Broadcast qualifier
);
	always @(posedge clock)
	begin
		if (!bus_busy)
			shutdown_n <= !pd_req;
		rx_match <= pkt_req && shutdown_n;
		// Qualifier means nothing outside a pulse, so it keeps moving;
		// the case test lifts it out of an unknown start
		rx_broadcast <= pkt_req ? pkt_bcast : (rx_broadcast !== 1'b1);
	end
endmodule

// ==== bench/test_radio_modem_power_mode_control.sv ====
// Self-checking bench of the radio power-mode controller
`timescale 1ns/1ps
module test_radio_modem_power_mode_control;
	// Short tick keeps phase lengths at tens of cycles
	localparam int TK = 20;
	localparam logic [4:0] A_CFG = {rpm_pkg::IDX_STBY_CFG, 2'b00};
	localparam logic [4:0] A_STB = {rpm_pkg::IDX_STBY_TIME, 2'b00};
	localparam logic [4:0] A_DSU = {rpm_pkg::IDX_DELIM_UNIT, 2'b00};
	localparam logic [4:0] A_SLP = {rpm_pkg::IDX_SLEEP_TIME, 2'b00};
	localparam logic [4:0] A_ACK = {rpm_pkg::IDX_ADDR_CHECK, 2'b00};
	localparam logic [4:0] A_CMD = {rpm_pkg::IDX_COMMAND, 2'b00};
	localparam logic [4:0] A_STS = {rpm_pkg::IDX_STATUS, 2'b00};
	logic clock, rst, pd_req, pkt_req, pkt_bcast, bus_busy;
	logic shutdown_n, rx_match, rx_broadcast, power_en, radio_en;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp, resp;
	int bad_count, comparisons, cyc, n;

	rpm_power_ctrl #(.TICK_CYCLES(TK)) rpm_power_ctrl_inst (
		.clock(clock), .rst(rst), .shutdown_n(shutdown_n),
		.rx_match(rx_match), .rx_broadcast(rx_broadcast),
		.power_en(power_en), .radio_en(radio_en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));
	rpm_host_model rpm_host_model_inst (
		.clock(clock), .pd_req(pd_req), .bus_busy(bus_busy),
		.pkt_req(pkt_req), .pkt_bcast(pkt_bcast),
		.shutdown_n(shutdown_n), .rx_match(rx_match),
		.rx_broadcast(rx_broadcast));

	// Free-running 50 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// Cut a hang short well above the expected run length
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			bad_count++;
			wrap_up();
		end
	end

	task automatic chk(input string w, input logic [31:0] e,
		input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic chk_rng(input string w, input int lo, input int hi,
		input int g);
		comparisons++;
		if (g < lo || g > hi)
		begin
			bad_count++;
			$display("[ERR] %s expected %0d..%0d seen %0d", w, lo, hi, g);
		end
	endtask
	// Handshakes are judged mid-cycle, acted on after the next rise
	task automatic axw(input logic [4:0] a, input logic [31:0] d);
		logic aw_hs, w_hs, done;
		done = 1'b0;
		bus_busy <= 1'b1;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done)
		begin
			@(negedge clock);
			aw_hs = awvalid && awready;
			w_hs = wvalid && wready;
			done = bvalid;
			resp = bresp;
			@(posedge clock);
			if (aw_hs)
				awvalid <= 1'b0;
			if (w_hs)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		bus_busy <= 1'b0;
		// One idle edge, so a next call never re-raises in the same step
		@(posedge clock);
	endtask
	task automatic axr(input logic [4:0] a);
		logic ar_hs, done;
		done = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done)
		begin
			@(negedge clock);
			ar_hs = arvalid && arready;
			done = rvalid;
			rd = rdata;
			resp = rresp;
			@(posedge clock);
			if (ar_hs)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rchk(input string w, input logic [4:0] a,
		input logic [31:0] e);
		axr(a);
		chk(w, e, rd);
	endtask
	task automatic cmd(input logic [7:0] c, input logic [7:0] g);
		axw(A_CMD, {16'h0000, g, c});
	endtask
	// Wait for the radio to reach a level, then count how long it stays
	task automatic run(input logic lvl, output int k);
		k = 0;
		@(negedge clock);
		while (radio_en !== lvl)
			@(negedge clock);
		while (radio_en === lvl && k < 5000)
		begin
			@(negedge clock);
			k++;
		end
		@(posedge clock);
	endtask
	// Deliver one packet at the start of a standby phase and time it
	task automatic pkt(input logic b, input int lo, input int hi);
		run(1'b0, n);
		pkt_req <= 1'b1;
		pkt_bcast <= b;
		@(posedge clock);
		pkt_req <= 1'b0;
		run(1'b1, n);
		chk_rng("extended standby", lo, hi, n);
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		{rst, pd_req, pkt_req, pkt_bcast, bus_busy} = 5'b10000;
		{awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
		{awaddr, araddr, wdata, wstrb} = '0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		repeat (5) @(posedge clock);
		chk("power_en", 1'b1, power_en);
		chk("radio_en", 1'b1, radio_en);
		rchk("cfg", A_CFG, 32'h09);
		rchk("stby", A_STB, 32'h04);
		rchk("unit", A_DSU, 32'hc1);
		rchk("sleep", A_SLP, 32'h04);
		rchk("check", A_ACK, 32'h8d);
		axr(5'h1c);
		chk("unmapped", rpm_pkg::RESP_SLVERR, resp);
		$display("test defaults done");
		cmd(rpm_pkg::CMD_STBY_TIME, 8'h02);
		chk("write resp", rpm_pkg::RESP_OKAY, resp);
		cmd(rpm_pkg::CMD_SLEEP_TIME, 8'h03);
		axw(A_CMD, 32'hff);
		chk("bad code", rpm_pkg::RESP_SLVERR, resp);
		rchk("stby set", A_STB, 32'h02);
		rchk("sleep set", A_SLP, 32'h03);
		cmd(rpm_pkg::CMD_LP_ON, 8'h00);
		rchk("status on", A_STS, 32'h1d);
		run(1'b0, n);
		chk_rng("sleep", 2 * TK, 3 * TK + 3, n);
		run(1'b1, n);
		chk_rng("standby", TK, 2 * TK + 3, n);
		axw(A_DSU, 32'hc3);
		axw(A_SLP, 32'h01);
		// The writes land inside a running sleep; the new length applies
		// only from the sleep after the next standby
		run(1'b1, n);
		chk_rng("standby again", TK, 2 * TK + 3, n);
		run(1'b0, n);
		chk_rng("long sleep", 9 * TK, 10 * TK + 3, n);
		axw(A_DSU, 32'hc1);
		$display("test cycle done");
		cmd(rpm_pkg::CMD_EXT_TIME, 8'h04);
		rchk("cfg ext", A_CFG, 32'h49);
		pkt(1'b0, 4 * TK, 6 * TK + 5);
		pkt(1'b1, 1, 2 * TK + 5);
		axw(A_ACK, 32'h8c);
		pkt(1'b0, 1, 2 * TK + 5);
		axw(A_ACK, 32'h8d);
		$display("test extension done");
		cmd(rpm_pkg::CMD_LP_OFF, 8'h00);
		rchk("status off", A_STS, 32'h14);
		repeat (100) @(posedge clock);
		chk("radio idle", 1'b1, radio_en);
		cmd(rpm_pkg::CMD_RADIO_OFF, 8'h00);
		repeat (2) @(posedge clock);
		chk("radio off", 1'b0, radio_en);
		cmd(rpm_pkg::CMD_RADIO_ON, 8'h00);
		repeat (2) @(posedge clock);
		chk("radio on", 1'b1, radio_en);
		$display("test radio done");
		axw(A_CFG, 32'h0d);
		rchk("status cfg", A_STS, 32'h15);
		axw(A_STB, 32'h05);
		cmd(rpm_pkg::CMD_LP_ON, 8'h00);
		cmd(rpm_pkg::CMD_RADIO_OFF, 8'h00);
		pd_req <= 1'b1;
		repeat (5) @(posedge clock);
		chk("pd power", 1'b0, power_en);
		chk("pd radio", 1'b0, radio_en);
		axw(A_STB, 32'h07);
		chk("pd write", rpm_pkg::RESP_SLVERR, resp);
		pd_req <= 1'b0;
		repeat (5) @(posedge clock);
		chk("up power", 1'b1, power_en);
		chk("up radio", 1'b1, radio_en);
		rchk("stby clr", A_STB, 32'h04);
		rchk("cfg clr", A_CFG, 32'h09);
		rchk("status up", A_STS, 32'h14);
		$display("test power-down done");
		wrap_up();
	end
endmodule
